// >>> core/tpms_ctrl.sv
/*
 * Test pin mode and sleep control: decides when the shared test pins
 * serve boundary scan, runs the test access port state machine on the
 * test clock, routes probe nets, and gates everything in low power.
 * Assumes the test clock is clocked into tck_i by the pad ring and that
 * fuses are static levels.
 */
// Functional notes
// - Low power: core off, inputs off, outputs tristated
// - Registers lost across low power mode
// - Program fuse picks dedicated or flexible mode
// - Dedicated: test pins only, select and data pull-ups on
// - Dedicated: mode-select drives standard state machine
// - Flexible: select and data pull-ups off, pins are user I/O
// - Flexible: clock edge with select low claims
// - Claim held until logic-reset, then released
// - Five clocks with select high reach reset
// - Reserved test reset: async active-low, pull-up
// - Unreserved test reset: user I/O, no pull-up
// - Probe selections via scan port reach outputs
// - Security fuse permanently disables probe outputs
`timescale 1ns/1ps
module tpms_ctrl (
   // Core clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Test link clock and pins
   input wire logic tck_i,
   input wire tpms_pkg::tpms_pin_in_t pin_i,
   output tpms_pkg::tpms_pin_out_t pin_o,
   // Static configuration
   input wire logic program_fuse_i,
   input wire logic security_fuse_i,
   input wire logic reserve_trst_i,
   input wire logic low_power_request_pin_i,
   // Internal nets to observe
   input wire logic [tpms_pkg::TPMS_NET_N-1:0] nets_i,
   output tpms_pkg::tpms_probe_t probe_o,
   // Core side status
   output logic pins_claimed_o,
   output logic trst_user_oe_o,
   output logic core_power_on_o,
   output logic input_buf_en_o
);
   import tpms_pkg::*;

   // ---------------------------------------------------------------
   // Low power and test reset qualification
   // ---------------------------------------------------------------
   logic sleep;
   logic dedicated;
   logic tap_rst_n;
   assign dedicated = program_fuse_i;
   assign sleep = low_power_request_pin_i;
   assign tap_rst_n = ~(reserve_trst_i & ~pin_i.trst_n) & ~sleep;

   // ---------------------------------------------------------------
   // Test clock domain
   // ---------------------------------------------------------------
   tpms_tap_t tap;
   tpms_tap_t next_tap;
   logic claimed;
   logic next_claimed;
   logic [TPMS_IR_W-1:0] ir;
   logic [TPMS_IR_W-1:0] next_ir;
   logic [TPMS_SEL_W-1:0] sel_sh;
   logic [TPMS_SEL_W-1:0] next_sel_sh;
   logic [TPMS_SEL_W-1:0] sel;
   logic [TPMS_SEL_W-1:0] next_sel;
   logic [TPMS_IR_W-1:0] ir_sh;
   logic [TPMS_IR_W-1:0] next_ir_sh;
   logic active;

   assign active = dedicated | claimed;

   always_comb begin
      next_tap = tap;
      // five high clocks reach reset from anywhere
      case (tap)
         TPMS_RESET: next_tap = pin_i.tms ? TPMS_RESET : TPMS_IDLE;
         TPMS_IDLE: next_tap = pin_i.tms ? TPMS_SEL_DR : TPMS_IDLE;
         TPMS_SEL_DR: next_tap = pin_i.tms ? TPMS_SEL_IR : TPMS_CAP_DR;
         TPMS_CAP_DR: next_tap = pin_i.tms ? TPMS_EX1_DR : TPMS_SH_DR;
         TPMS_SH_DR: next_tap = pin_i.tms ? TPMS_EX1_DR : TPMS_SH_DR;
         TPMS_EX1_DR: next_tap = pin_i.tms ? TPMS_UPD_DR : TPMS_PA_DR;
         TPMS_PA_DR: next_tap = pin_i.tms ? TPMS_EX2_DR : TPMS_PA_DR;
         TPMS_EX2_DR: next_tap = pin_i.tms ? TPMS_UPD_DR : TPMS_SH_DR;
         TPMS_UPD_DR: next_tap = pin_i.tms ? TPMS_SEL_DR : TPMS_IDLE;
         TPMS_SEL_IR: next_tap = pin_i.tms ? TPMS_RESET : TPMS_CAP_IR;
         TPMS_CAP_IR: next_tap = pin_i.tms ? TPMS_EX1_IR : TPMS_SH_IR;
         TPMS_SH_IR: next_tap = pin_i.tms ? TPMS_EX1_IR : TPMS_SH_IR;
         TPMS_EX1_IR: next_tap = pin_i.tms ? TPMS_UPD_IR : TPMS_PA_IR;
         TPMS_PA_IR: next_tap = pin_i.tms ? TPMS_EX2_IR : TPMS_PA_IR;
         TPMS_EX2_IR: next_tap = pin_i.tms ? TPMS_UPD_IR : TPMS_SH_IR;
         TPMS_UPD_IR: next_tap = pin_i.tms ? TPMS_SEL_DR : TPMS_IDLE;
         default: next_tap = TPMS_RESET;
      endcase
      // Flexible mode: state machine idles in reset until claimed
      if (!active && pin_i.tms) begin
         next_tap = TPMS_RESET;
      end
   end

   always_comb begin
      next_claimed = claimed;
      // rising clock with select low claims
      if (!dedicated && !pin_i.tms) begin
         next_claimed = 1'b1;
      end
      else if (!dedicated && next_tap == TPMS_RESET) begin
         next_claimed = 1'b0;
      end
   end

   always_comb begin
      next_ir_sh = ir_sh;
      next_ir = ir;
      next_sel_sh = sel_sh;
      next_sel = sel;
      case (tap)
         TPMS_CAP_IR: next_ir_sh = TPMS_IR_PROBE;
         TPMS_SH_IR: next_ir_sh = {pin_i.tdi, ir_sh[TPMS_IR_W-1:1]};
         TPMS_UPD_IR: next_ir = ir_sh;
         TPMS_CAP_DR: next_sel_sh = sel;
         TPMS_SH_DR: begin
            if (ir == TPMS_IR_PROBE) begin
               next_sel_sh = {pin_i.tdi, sel_sh[TPMS_SEL_W-1:1]};
            end
         end
         TPMS_UPD_DR: begin
            if (ir == TPMS_IR_PROBE) begin
               next_sel = sel_sh;
            end
         end
         default: next_ir_sh = ir_sh;
      endcase
      if (tap == TPMS_RESET) begin
         next_ir = TPMS_IR_RST;
      end
   end

   always_ff @(posedge tck_i or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         tap <= TPMS_RESET;
         claimed <= 1'b0;
         ir <= TPMS_IR_RST;
         ir_sh <= TPMS_IR_RST;
         sel_sh <= TPMS_SEL_RST;
         sel <= TPMS_SEL_RST;
      end else begin
         tap <= next_tap;
         claimed <= next_claimed;
         ir <= next_ir;
         ir_sh <= next_ir_sh;
         sel_sh <= next_sel_sh;
         sel <= next_sel;
      end
   end

   // Data out changes on the falling test clock, as the standard wants
   logic tdo_q;
   logic next_tdo_q;
   logic shifting;
   assign shifting = (tap == TPMS_SH_DR) | (tap == TPMS_SH_IR);
   always_comb begin
      next_tdo_q = 1'b0;
      if (tap == TPMS_SH_IR) begin
         next_tdo_q = ir_sh[0];
      end else if (tap == TPMS_SH_DR && ir == TPMS_IR_PROBE) begin
         next_tdo_q = sel_sh[0];
      end else if (tap == TPMS_SH_DR) begin
         next_tdo_q = pin_i.tdi;
      end
   end
   always_ff @(negedge tck_i or negedge tap_rst_n) begin
      if (!tap_rst_n) begin
         tdo_q <= 1'b0;
      end else begin
         tdo_q <= next_tdo_q;
      end
   end

   // ---------------------------------------------------------------
   // Pin drive and pull-ups
   // ---------------------------------------------------------------
   always_comb begin
      pin_o.tdo = tdo_q;
      pin_o.tdo_oe = active & shifting & ~sleep;
      pin_o.tms_pu = dedicated & ~sleep;
      pin_o.tdi_pu = dedicated & ~sleep;
      pin_o.trst_pu = reserve_trst_i & ~sleep;
   end

   // ---------------------------------------------------------------
   // Core clock domain: synchronise claim state and selection
   // ---------------------------------------------------------------
   logic [1:0] claim_sync;
   logic [1:0] next_claim_sync;
   logic [TPMS_SEL_W-1:0] sel_s1;
   logic [TPMS_SEL_W-1:0] sel_s2;
   logic [TPMS_SEL_W-1:0] next_sel_s1;
   logic [TPMS_SEL_W-1:0] next_sel_s2;
   logic pa;
   logic pb;
   logic next_pa;
   logic next_pb;
   logic probe_en;

   // Selection is only rewritten in update, so a settled pair is safe;
   // a torn value lasts at most one core cycle on the probe outputs.
   always_comb begin
      next_claim_sync = {claim_sync[0], active};
      next_sel_s1 = sel;
      next_sel_s2 = sel_s1;
      probe_en = ~security_fuse_i & ~sleep;
      next_pa = probe_en & nets_i[sel_s2];
      next_pb = probe_en &
         nets_i[TPMS_SEL_W'(sel_s2 + TPMS_SEL_W'(1))];
   end

   // sleep clears core state, nothing retained
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || sleep) begin
         claim_sync <= 2'h0;
         sel_s1 <= TPMS_SEL_RST;
         sel_s2 <= TPMS_SEL_RST;
         pa <= 1'b0;
         pb <= 1'b0;
      end else begin
         claim_sync <= next_claim_sync;
         sel_s1 <= next_sel_s1;
         sel_s2 <= next_sel_s2;
         pa <= next_pa;
         pb <= next_pb;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      probe_o.probe_a = pa;
      probe_o.probe_b = pb;
      probe_o.probe_oe = ~security_fuse_i & ~sleep;
      pins_claimed_o = claim_sync[1];
      // unreserved test reset is user I/O
      trst_user_oe_o = ~reserve_trst_i & ~sleep;
      core_power_on_o = ~sleep;
      input_buf_en_o = ~sleep;
   end
endmodule : tpms_ctrl

// >>> core/tpms_pkg.sv
/*
 * Package for the test pin mode and sleep control block: TAP states,
 * widths, reset and instruction codes, and the grouped pin and probe carriers.
 * Assumes a 50 MHz core clock and a separately clocked test link.
 */
package tpms_pkg;
   // ---------------------------------------------------------------
   // Test access port states, Gray codes along the reset/idle path
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      TPMS_RESET = 4'h0,
      TPMS_IDLE = 4'h1,
      TPMS_SEL_DR = 4'h3,
      TPMS_CAP_DR = 4'h2,
      TPMS_SH_DR = 4'h6,
      TPMS_EX1_DR = 4'h7,
      TPMS_PA_DR = 4'h5,
      TPMS_EX2_DR = 4'h4,
      TPMS_UPD_DR = 4'hc,
      TPMS_SEL_IR = 4'hd,
      TPMS_CAP_IR = 4'hf,
      TPMS_SH_IR = 4'he,
      TPMS_EX1_IR = 4'ha,
      TPMS_PA_IR = 4'hb,
      TPMS_EX2_IR = 4'h9,
      TPMS_UPD_IR = 4'h8
   } tpms_tap_t;

   // ---------------------------------------------------------------
   // Constants
   // ---------------------------------------------------------------
   localparam int TPMS_SEL_W = 4;
   localparam int TPMS_NET_N = 16;
   localparam logic [TPMS_SEL_W-1:0] TPMS_SEL_RST = 4'h0;
   localparam int TPMS_IR_W = 2;
   localparam logic [TPMS_IR_W-1:0] TPMS_IR_RST = 2'h0;
   localparam logic [TPMS_IR_W-1:0] TPMS_IR_PROBE = 2'h1;
   localparam logic [TPMS_IR_W-1:0] TPMS_IR_BYPASS = 2'h3;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } tpms_pin_in_t;

   typedef struct packed {
      logic tdo;
      logic tdo_oe;
      logic tms_pu;
      logic tdi_pu;
      logic trst_pu;
   } tpms_pin_out_t;

   typedef struct packed {
      logic probe_a;
      logic probe_b;
      logic probe_oe;
   } tpms_probe_t;
endpackage : tpms_pkg

// >>> verif/tpms_ctrl_sva.sv
/* Port checker for tpms_ctrl.
   Assumes a bind to tpms_ctrl and one core clock domain. */
`timescale 1ns/1ps
module tpms_ctrl_sva (
   // Clock, reset and inputs
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire tpms_pkg::tpms_pin_in_t pin_i,
   input wire logic program_fuse_i,
   input wire logic security_fuse_i,
   input wire logic reserve_trst_i,
   input wire logic low_power_request_pin_i,
   // Outputs watched
   input wire tpms_pkg::tpms_pin_out_t pin_o,
   input wire tpms_pkg::tpms_probe_t probe_o,
   input wire logic pins_claimed_o,
   input wire logic trst_user_oe_o,
   input wire logic core_power_on_o,
   input wire logic input_buf_en_o
);
   import tpms_pkg::*;
   logic lp;
   assign lp = low_power_request_pin_i;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Six edges cover the two-flop sync with margin
   sequence s_ded_held;
      (program_fuse_i && !lp)[*6];
   endsequence
   sequence s_trst_held;
      (!program_fuse_i && reserve_trst_i && !pin_i.trst_n)[*6];
   endsequence
   property p_sleep_off;
      lp |-> !core_power_on_o && !input_buf_en_o;
   endproperty
   property p_sleep_hiz;
      lp |-> !pin_o.tdo_oe && !probe_o.probe_oe;
   endproperty
   property p_pullup;
      pin_o.tms_pu == (program_fuse_i && !lp) && pin_o.tdi_pu == pin_o.tms_pu;
   endproperty
   property p_trst_pu;
      pin_o.trst_pu == (reserve_trst_i && !lp);
   endproperty
   property p_trst_user;
      trst_user_oe_o == (!reserve_trst_i && !lp);
   endproperty
   property p_secure;
      security_fuse_i && $past(security_fuse_i) |->
         !probe_o.probe_oe && !probe_o.probe_a && !probe_o.probe_b;
   endproperty
   property p_ded;
      s_ded_held |-> pins_claimed_o;
   endproperty
   property p_lp_clear;
      lp |=> !pins_claimed_o;
   endproperty
   property p_flex_trst;
      s_trst_held |-> !pins_claimed_o;
   endproperty
   a_sleep_off: assert property (p_sleep_off)
      else $error("sleep left core powered");
   a_sleep_hiz: assert property (p_sleep_hiz)
      else $error("sleep left an output driven");
   a_pullup: assert property (p_pullup)
      else $error("select or data pull-up wrong");
   a_trst_pu: assert property (p_trst_pu)
      else $error("test reset pull-up wrong");
   a_trst_user: assert property (p_trst_user)
      else $error("test reset user enable wrong");
   a_secure: assert property (p_secure)
      else $error("probe active with security set");
   a_ded: assert property (p_ded)
      else $error("dedicated mode not claimed");
   a_lp_clear: assert property (p_lp_clear)
      else $error("claim kept through sleep");
   a_flex_trst: assert property (p_flex_trst)
      else $error("claim kept under test reset");
endmodule : tpms_ctrl_sva
bind tpms_ctrl tpms_ctrl_sva chk_u (.clock_i, .rst_n_i, .pin_i,
   .program_fuse_i, .security_fuse_i, .reserve_trst_i,
   .low_power_request_pin_i, .pin_o, .probe_o, .pins_claimed_o,
   .trst_user_oe_o, .core_power_on_o, .input_buf_en_o);

// >>> verif/tpms_tester.sv
/* Behavioural scan tester on the test clock side.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
module tpms_tester (
   // Test pins driven
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   output logic trst_n_o,
   // Data back
   input wire logic tdo_i
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
      trst_n_o = 1'b1;
   end
   // clock moves only inside a tick
   task tick(input logic m, input logic d, output logic q);
      tms_o = m;
      tdi_o = d;
      #3.75;
      q = tdo_i;
      tck_o = 1'b1;
      #7.5;
      tck_o = 1'b0;
      #3.75;
      tdi_o = ~d;
   endtask : tick
   task park;
      logic q;
      repeat (5) tick(1'b1, 1'b0, q);
   endtask : park
   // idle to shift, out, back to idle
   task scan(input logic ir, input logic [3:0] v, input int n,
         output logic [3:0] cap);
      logic q;
      tick(1'b1, 1'b0, q);
      if (ir) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
      tick(1'b0, 1'b0, q);
      cap = 4'h0;
      for (int i = 0; i < n; i++) tick(i == n - 1, v[i], cap[i]);
      tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask : scan
endmodule : tpms_tester

// >>> verif/tpms_ctrl_test.sv
/* Self-checking bench for tpms_ctrl with a scan tester model.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
module tpms_ctrl_test;
   import tpms_pkg::*;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic fuse = 1'b0;
   logic secure = 1'b0;
   logic reserve = 1'b0;
   logic lp = 1'b0;
   logic [15:0] nets = 16'h8000;
   logic tck, tms, tdi, trst_n, claimed, user_oe, pwr, ibuf, q;
   logic [3:0] cap;
   tpms_pin_out_t pin_o;
   tpms_probe_t probe_o;
   int bad_count = 0;
   int comparisons = 0;
   always #10 clock_i = ~clock_i;
   tpms_tester tester_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
      .trst_n_o(trst_n), .tdo_i(pin_o.tdo));
   tpms_ctrl dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .tck_i(tck),
      .pin_i({tck, tms, tdi, trst_n}), .pin_o(pin_o),
      .program_fuse_i(fuse), .security_fuse_i(secure),
      .reserve_trst_i(reserve), .low_power_request_pin_i(lp),
      .nets_i(nets), .probe_o(probe_o), .pins_claimed_o(claimed),
      .trst_user_oe_o(user_oe), .core_power_on_o(pwr),
      .input_buf_en_o(ibuf));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task wclk(input int n);
      repeat (n) @(negedge clock_i);
   endtask : wclk
   task claim;
      tester_u.tick(1'b0, 1'b0, q);
      wclk(6);
   endtask : claim
   task t_flex;
      tester_u.tick(1'b1, 1'b0, q);
      wclk(6);
      chk(claimed, 1'b0);
      chk({pin_o.tms_pu, pin_o.tdi_pu}, 2'b00);
      claim();
      chk(claimed, 1'b1);
      tester_u.tick(1'b1, 1'b0, q);
      wclk(6);
      chk(claimed, 1'b1);
      tester_u.park();
      wclk(6);
      chk(claimed, 1'b0);
   endtask : t_flex
   task t_probe;
      claim();
      tester_u.scan(1'b1, 4'h1, 2, cap);
      chk(cap, 4'h1);
      tester_u.scan(1'b0, 4'hf, 4, cap);
      wclk(8);
      chk({probe_o.probe_a, probe_o.probe_b, probe_o.probe_oe}, 3'h5);
      secure = 1'b1;
      wclk(4);
      chk({probe_o.probe_a, probe_o.probe_b, probe_o.probe_oe}, 3'h0);
      secure = 1'b0;
      tester_u.park();
      wclk(6);
      chk(claimed, 1'b0);
   endtask : t_probe
   task t_trst;
      reserve = 1'b1;
      claim();
      chk({pin_o.trst_pu, user_oe}, 2'b10);
      tester_u.trst_n_o = 1'b0;
      wclk(6);
      chk(claimed, 1'b0);
      reserve = 1'b0;
      tester_u.trst_n_o = 1'b1;
      claim();
      tester_u.trst_n_o = 1'b0;
      wclk(6);
      chk({claimed, pin_o.trst_pu, user_oe}, 3'b101);
      tester_u.trst_n_o = 1'b1;
      tester_u.park();
   endtask : t_trst
   task t_ded;
      fuse = 1'b1;
      wclk(6);
      chk({pin_o.tms_pu, pin_o.tdi_pu, claimed}, 3'b111);
      tester_u.park();
      wclk(6);
      chk(claimed, 1'b1);
      fuse = 1'b0;
      wclk(6);
      chk(claimed, 1'b0);
   endtask : t_ded
   task t_sleep;
      claim();
      lp = 1'b1;
      wclk(2);
      chk({pwr, ibuf, pin_o.tdo_oe, probe_o.probe_oe, claimed}, 5'h0);
      lp = 1'b0;
      rst_n_i = 1'b0;
      wclk(2);
      rst_n_i = 1'b1;
      wclk(6);
      chk({pwr, ibuf, claimed}, 3'b110);
   endtask : t_sleep
   task close_out;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out
   initial begin
      wclk(16);
      rst_n_i = 1'b1;
      wclk(2);
      t_flex();
      t_probe();
      t_trst();
      t_ded();
      t_sleep();
      close_out();
   end
   // Whole run needs about 3 us
   initial begin
      #100000;
      bad_count++;
      close_out();
   end
endmodule : tpms_ctrl_test
